/* logic/rx_analog_power_override.sv */
/*
 * apb-controlled power override for the baseband amplifier and the
 * receive mixer buffer. assumes modem enables are synchronous to clk_sys.
 */
module rx_analog_power_override
	import rx_power_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic modem_bb_amp_en,
	input wire logic modem_mixer_buffer_en,
	output logic bb_amp_en,
	output logic mixer_buffer_en
);

	// ------------------------------------------------------------------
	// decode
	// ------------------------------------------------------------------
	function automatic logic stage_enable(input logic down_force,
		input logic up_force, input logic modem_en);
		logic en;
		en = 1'b1;
		if (down_force && up_force) begin
			en = modem_en;
		end else if (!down_force && up_force) begin
			en = 1'b0;
		end
		return en;
	endfunction : stage_enable

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	apb_req_t req;
	power_state_t st_ff;
	power_state_t nxt_st;
	logic setup;
	logic access;
	logic mapped;

	assign req = '{paddr: paddr, psel: psel, penable: penable,
		pwrite: pwrite, pwdata: pwdata, pstrb: pstrb};
	assign setup = req.psel && !req.penable;
	// read data is latched in setup, so access never needs a wait state
	assign access = req.psel && req.penable;
	assign mapped = (req.paddr == OFS_DOWN_FORCE) ||
		(req.paddr == OFS_UP_FORCE) || (req.paddr == OFS_STATUS);

	always_comb begin
		nxt_st = st_ff;
		if (setup) begin
			nxt_st.pslverr_ff = !mapped;
			nxt_st.prdata_ff = 32'h0000_0000;
			unique case (req.paddr)
				OFS_DOWN_FORCE: nxt_st.prdata_ff[7:0] = st_ff.down_force_ff;
				OFS_UP_FORCE: nxt_st.prdata_ff[7:0] = st_ff.up_force_ff;
				OFS_STATUS: begin
					nxt_st.prdata_ff[STAT_BB_AMP_EN] = st_ff.bb_amp_en_ff;
					nxt_st.prdata_ff[STAT_MIXER_BUFFER_EN] =
						st_ff.mixer_buffer_en_ff;
					nxt_st.prdata_ff[STAT_MODEM_BB_AMP] = modem_bb_amp_en;
					nxt_st.prdata_ff[STAT_MODEM_MIXER_BUFFER] =
						modem_mixer_buffer_en;
				end
				default: nxt_st.prdata_ff = 32'h0000_0000;
			endcase
		end
		// only byte lane 0 holds fields; other lanes are ignored
		if (access && req.pwrite && req.pstrb[0]) begin
			if (req.paddr == OFS_DOWN_FORCE) begin
				nxt_st.down_force_ff = req.pwdata[7:0] & DOWN_FORCE_MASK;
			end
			if (req.paddr == OFS_UP_FORCE) begin
				nxt_st.up_force_ff = req.pwdata[7:0] & UP_FORCE_MASK;
			end
		end
		// reserved bit 3 never enters the decode below
		nxt_st.bb_amp_en_ff = stage_enable(st_ff.down_force_ff[BIT_BB_AMP],
			st_ff.up_force_ff[BIT_BB_AMP], modem_bb_amp_en);
		nxt_st.mixer_buffer_en_ff = stage_enable(
			st_ff.down_force_ff[BIT_MIXER_BUFFER],
			st_ff.up_force_ff[BIT_MIXER_BUFFER],
			modem_mixer_buffer_en);
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			st_ff <= '{down_force_ff: DOWN_FORCE_RST,
				up_force_ff: UP_FORCE_RST, bb_amp_en_ff: 1'b0,
				mixer_buffer_en_ff: 1'b0, prdata_ff: 32'h0000_0000,
				pslverr_ff: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign pready = 1'b1;
	assign prdata = st_ff.prdata_ff;
	assign pslverr = st_ff.pslverr_ff && access;
	assign bb_amp_en = st_ff.bb_amp_en_ff;
	assign mixer_buffer_en = st_ff.mixer_buffer_en_ff;

endmodule : rx_analog_power_override

/* inc/rx_power_pkg.sv */
/*
 * constants and carriers of the receive analog power override block.
 * assumes a 32-bit apb slave port and a 100 mhz system clock.
 */
// ----------------------------------------------------------------------
// Notes on behaviour
// ----------------------------------------------------------------------
// Notes on behaviour
// - amplifier power-down field bit 5, reset zero
// - both fields one: amplifier follows modem
// - up one, down zero: amplifier forced off
// - mixer buffer power-down field bit 4, reset zero
// - mixer buffer four-way decode like amplifier
// - powered-down stage has its enable deasserted
package rx_power_pkg;

	// ------------------------------------------------------------------
	// register map
	// ------------------------------------------------------------------
	localparam logic [11:0] OFS_DOWN_FORCE = 12'h000;
	localparam logic [11:0] OFS_UP_FORCE = 12'h004;
	localparam logic [11:0] OFS_STATUS = 12'h008;
	localparam int ADDR_W = 12;

	// ------------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------------
	localparam int BIT_BB_AMP = 5;
	localparam int BIT_MIXER_BUFFER = 4;
	localparam int BIT_RESERVED = 3;
	localparam int STAT_BB_AMP_EN = 0;
	localparam int STAT_MIXER_BUFFER_EN = 1;
	localparam int STAT_MODEM_BB_AMP = 2;
	localparam int STAT_MODEM_MIXER_BUFFER = 3;
	localparam logic [7:0] DOWN_FORCE_RST = 8'h00;
	localparam logic [7:0] UP_FORCE_RST = 8'h30;
	localparam logic [7:0] DOWN_FORCE_MASK = 8'h38;
	localparam logic [7:0] UP_FORCE_MASK = 8'h30;

	// ------------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [ADDR_W-1:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
		logic [3:0] pstrb;
	} apb_req_t;

	typedef struct packed {
		logic [7:0] down_force_ff;
		logic [7:0] up_force_ff;
		logic bb_amp_en_ff;
		logic mixer_buffer_en_ff;
		logic [31:0] prdata_ff;
		logic pslverr_ff;
	} power_state_t;

endpackage : rx_power_pkg

/* sim/rx_power_properties.sv */
/* checker of the override block ports.
   assumes a bind from the bench top. */
module rx_power_properties import rx_power_pkg::*; (
	input wire logic clk_sys, reset_n, psel, penable, pwrite, pready,
	input wire logic pslverr, bb_amp_en, mixer_buffer_en,
	input wire logic modem_bb_amp_en, modem_mixer_buffer_en,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata, prdata,
	input wire logic [3:0] pstrb
);
	timeunit 1ns / 1ns;
	// shadow of the fields, so decode is checked without peeking inside
	logic [2:0] d_ff;
	logic [1:0] u_ff;
	wire acc = psel & penable;
	wire wr = acc & pwrite & pstrb[0];
	wire amp_x = !u_ff[1] | d_ff[2] & modem_bb_amp_en;
	wire mix_x = !u_ff[0] | d_ff[1] & modem_mixer_buffer_en;
	always_ff @(posedge clk_sys or negedge reset_n)
		if (!reset_n) {d_ff, u_ff} <= 5'h03;
		else if (wr && paddr == OFS_DOWN_FORCE) d_ff <= pwdata[5:3];
		else if (wr && paddr == OFS_UP_FORCE) u_ff <= pwdata[5:4];
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	a_amp_decode: assert property (bb_amp_en == $past(amp_x))
		else $error("amp enable wrong");
	a_mix_decode: assert property (mixer_buffer_en == $past(mix_x))
		else $error("mixer enable wrong");
	a_down_read: assert property (acc && paddr == OFS_DOWN_FORCE |->
		pwrite || prdata == 32'(d_ff) << 3) else $error("down readback");
	a_up_read: assert property (acc && paddr == OFS_UP_FORCE |->
		pwrite || prdata == 32'(u_ff) << 4) else $error("up readback");
	a_ready_high: assert property (pready) else $error("wait state");
	a_err_gated: assert property (pslverr |-> acc) else $error("stray error");
	a_err_unmap: assert property (acc && paddr > OFS_STATUS |-> pslverr)
		else $error("no error");
endmodule : rx_power_properties

/* sim/modem_model.sv */
/* modem model: stage requests, one cycle late.
   assumes the bench changes req after a clock edge. */
module modem_model (
	input wire logic clk_sys, reset_n,
	input wire logic [1:0] req,
	output logic modem_bb_amp_en, modem_mixer_buffer_en
);
	timeunit 1ns / 1ns;
	always_ff @(posedge clk_sys or negedge reset_n)
		if (!reset_n) {modem_bb_amp_en, modem_mixer_buffer_en} <= 2'h0;
		else {modem_bb_amp_en, modem_mixer_buffer_en} <= req;
endmodule : modem_model

/* sim/rx_analog_power_override_tb.sv */
/* bench top: apb master, modem model, checker bind.
   assumes the package constants. */
module rx_analog_power_override_tb import rx_power_pkg::*; ;
	timeunit 1ns / 1ns;
	logic clk_sys = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [1:0] req = 2'h0;
	logic pready, pslverr, er, bb_amp_en, mixer_buffer_en;
	logic modem_bb_amp_en, modem_mixer_buffer_en;
	int err_count = 0, checks = 0, cyc = 0;
	always #5 clk_sys = ~clk_sys;
	modem_model u_modem (.*);
	rx_analog_power_override u_dut (.*, .pstrb(4'hf));
	always @(posedge clk_sys) if (++cyc == 2000) begin
		err_count++;
		give_verdict;
	end
	task give_verdict;
		if (err_count == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : give_verdict
	task cmp(input string n, input logic [31:0] e, s);
		checks++;
		if (s !== e) begin
			err_count++;
			$display("unexpected %s exp %h got %h", n, e, s);
		end
	endtask : cmp
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge clk_sys) penable <= 1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		{rd, er} = {prdata, pslverr};
		{psel, penable} <= 2'h0;
		@(posedge clk_sys);
	endtask : apb
	task t_regs;
		apb(0, OFS_DOWN_FORCE, 0);
		cmp("down", 32'h0, rd);
		apb(1, OFS_DOWN_FORCE, 32'h8);
		apb(0, OFS_DOWN_FORCE, 0);
		cmp("reserved", 32'h8, rd);
		cmp("enables", 0, {bb_amp_en, mixer_buffer_en});
		apb(0, 12'h00c, 0);
		cmp("error", 1, er);
		cmp("unmapped read", 0, rd);
	endtask : t_regs
	// every field pair against every modem request, both stages at once
	task t_decode;
		for (int i = 0; i < 16; i++) begin
			apb(1, OFS_DOWN_FORCE, 32'(i[1:0]) << 4);
			apb(1, OFS_UP_FORCE, 32'(i[3:2]) << 4);
			for (int j = 0; j < 4; j++) begin
				req <= 2'(j);
				repeat (3) @(posedge clk_sys);
				cmp("amp", 32'(!i[3] || i[1] && j[1]), bb_amp_en);
				cmp("mix", 32'(!i[2] || i[0] && j[0]), mixer_buffer_en);
			end
		end
	endtask : t_decode
	// both stages follow the modem; status shows enables and requests
	task t_status;
		req <= 2'h2;
		repeat (3) @(posedge clk_sys);
		apb(0, OFS_STATUS, 0);
		cmp("status", 32'h5, rd);
		apb(1, OFS_STATUS, 32'hff);
		cmp("status wr error", 0, er);
		apb(0, OFS_STATUS, 0);
		cmp("status after wr", 32'h5, rd);
	endtask : t_status
	initial begin
		repeat (5) @(posedge clk_sys);
		reset_n <= 1;
		@(posedge clk_sys);
		t_regs;
		t_decode;
		t_status;
		give_verdict;
	end
endmodule : rx_analog_power_override_tb
bind rx_analog_power_override rx_power_properties u_chk (.*);
